// >>> logic/epb_pkg.sv
// constants for the program-memory and i/o bus port block
// Function
// - latch address, select and chip selects at strobe
// - respond only when both latched selects active
// - drive bus while a read strobe low
// - select high reads port, low reads memory
// - memory byte from eleven-bit latched address
// - high address inputs ignored for i/o
// - port write strobe loads selected resource
// - port read strobe equals i/o memory read
// - address 00 first port, 01 second port
// - wait low during strobe, released next clock
// - two eight-bit direction registers, per bit
// - direction 0 input, 1 output from latch
// - reset clears both direction registers
// - direction registers cannot be read back
// - address 10 and 11 select direction registers
// - latch updated, pins change at strobe release
// - latch writable while driver off; read gives latch on output bits, pin level on input bits
package epb_pkg;
    localparam int          LOW_ADDR_W     = 8;
    localparam int          HIGH_ADDR_W    = 3;
    localparam int          MEM_ADDR_W     = 11;
    localparam int          MEM_DEPTH      = 2048;
    localparam int          PORT_W         = 8;
    localparam logic [1:0]  SEL_PORT_FIRST = 2'h0;
    localparam logic [1:0]  SEL_PORT_SECOND = 2'h1;
    localparam logic [1:0]  SEL_DIR_FIRST  = 2'h2;
    localparam logic [1:0]  SEL_DIR_SECOND = 2'h3;
    localparam logic [7:0]  DIR_RESET      = 8'h00;
    localparam logic [7:0]  OUT_RESET      = 8'h00;
    localparam logic [7:0]  ADDR_RESET     = 8'h00;
    localparam logic [7:0]  DIR_READ_VALUE = 8'h00;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;
endpackage : epb_pkg

// >>> logic/epb_io_port.sv
// one general-purpose port: output latch, direction register, pin drivers
`timescale 1ns/100ps
module epb_io_port #(
    parameter int WIDTH = epb_pkg::PORT_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // staging from the bus side
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             stage_data,
    input  wire logic             stage_dir,
    input  wire logic             commit,
    // pins
    input  wire logic [WIDTH-1:0] pins_in,
    output logic      [WIDTH-1:0] pins_out,
    output logic      [WIDTH-1:0] pins_oe,
    // read-back of the pin levels
    output logic      [WIDTH-1:0] read_value
);
    import epb_pkg::*;

    logic [WIDTH-1:0] out_latch;
    logic [WIDTH-1:0] dir_stage;
    logic             pend_data;
    logic             pend_dir;
    logic [WIDTH-1:0] next_out_latch;
    logic [WIDTH-1:0] next_dir_stage;
    logic             next_pend_data;
    logic             next_pend_dir;
    logic [WIDTH-1:0] next_pins_out;
    logic [WIDTH-1:0] next_pins_oe;

    // latch takes data while strobe low, pins follow only on commit
    always_comb begin
        next_out_latch = stage_data ? wr_data : out_latch;
        next_dir_stage = stage_dir ? wr_data : dir_stage;
        next_pend_data = commit ? 1'b0 : (pend_data | stage_data);
        next_pend_dir  = commit ? 1'b0 : (pend_dir | stage_dir);
        next_pins_out  = (commit && pend_data) ? out_latch : pins_out;
        next_pins_oe   = (commit && pend_dir) ? dir_stage : pins_oe;
    end

    // register the port state; reset makes every pin an input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_latch <= WIDTH'(OUT_RESET);
            dir_stage <= WIDTH'(DIR_RESET);
            pend_data <= 1'b0;
            pend_dir  <= 1'b0;
            pins_out  <= WIDTH'(OUT_RESET);
            pins_oe   <= WIDTH'(DIR_RESET);
        end else begin
            out_latch <= next_out_latch;
            dir_stage <= next_dir_stage;
            pend_data <= next_pend_data;
            pend_dir  <= next_pend_dir;
            pins_out  <= next_pins_out;
            pins_oe   <= next_pins_oe;
        end
    end

    // per-bit read-back: driven level for outputs, sampled level for inputs
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_read
            assign read_value[i] = pins_oe[i] ? pins_out[i] : pins_in[i];
        end
    endgenerate
endmodule : epb_io_port

// >>> logic/epb_eprom_io_bus_port.sv
// bus slave of the program-memory and i/o chip with two ports
`timescale 1ns/100ps
module epb_eprom_io_bus_port #(
    parameter logic [epb_pkg::MEM_DEPTH*8-1:0] MEM_INIT = '1
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // multiplexed address/data bus
    input  wire logic [epb_pkg::LOW_ADDR_W-1:0]  muxed_addr_data_bus_in,
    output logic      [epb_pkg::LOW_ADDR_W-1:0]  muxed_addr_data_bus_out,
    output logic                                 muxed_addr_data_bus_oe,
    // address phase
    input  wire logic                           addr_strobe,
    input  wire logic                           mem_io_select,
    input  wire logic [epb_pkg::HIGH_ADDR_W-1:0] high_prom_address,
    input  wire logic                           chip_select_low_active_n,
    input  wire logic                           chip_select_high_active,
    // data phase strobes
    input  wire logic                           mem_read_strobe_n,
    input  wire logic                           port_read_strobe_n,
    input  wire logic                           port_write_strobe_n,
    // wait output
    output logic                                bus_wait_out,
    output logic                                bus_wait_oe,
    // first port pins
    input  wire logic [epb_pkg::PORT_W-1:0]      first_port_pins_in,
    output logic      [epb_pkg::PORT_W-1:0]      first_port_pins_out,
    output logic      [epb_pkg::PORT_W-1:0]      first_port_pins_oe,
    // second port pins
    input  wire logic [epb_pkg::PORT_W-1:0]      second_port_pins_in,
    output logic      [epb_pkg::PORT_W-1:0]      second_port_pins_out,
    output logic      [epb_pkg::PORT_W-1:0]      second_port_pins_oe
);
    import epb_pkg::*;

    logic [LOW_ADDR_W-1:0]  addr_lat;
    logic [HIGH_ADDR_W-1:0] high_lat;
    logic                   io_lat;
    logic                   cs_lat;
    logic                   wr_n_q;
    logic [LOW_ADDR_W-1:0]  next_addr_lat;
    logic [HIGH_ADDR_W-1:0] next_high_lat;
    logic                   next_io_lat;
    logic                   next_cs_lat;
    logic [LOW_ADDR_W-1:0]  next_bus_out;
    logic                   next_bus_oe;
    logic                   next_wait_oe;
    logic                   cs_now;
    logic [1:0]             sel;
    logic [MEM_ADDR_W-1:0]  mem_addr;
    logic [7:0]             mem_byte;
    logic                   rd_mem;
    logic                   rd_port;
    logic                   wr_sel;
    logic                   commit;
    logic [PORT_W-1:0]      first_rv;
    logic [PORT_W-1:0]      second_rv;

    // live chip select and decode of the latched address
    assign cs_now   = !chip_select_low_active_n && chip_select_high_active;
    assign sel      = addr_lat[1:0];
    assign mem_addr = {high_lat, addr_lat};
    assign mem_byte = MEM_INIT[{mem_addr, 3'h0} +: 8];
    assign rd_mem   = !mem_read_strobe_n;
    assign rd_port  = !port_read_strobe_n || (io_lat && rd_mem);
    assign wr_sel   = cs_lat && !port_write_strobe_n;
    assign commit   = !wr_n_q && port_write_strobe_n;

    // address latch follows inputs while strobe high, holds after its fall
    always_comb begin
        next_addr_lat = addr_lat;
        next_high_lat = high_lat;
        next_io_lat   = io_lat;
        next_cs_lat   = cs_lat;
        if (addr_strobe) begin
            next_addr_lat = muxed_addr_data_bus_in;
            next_high_lat = high_prom_address;
            next_io_lat   = mem_io_select;
            next_cs_lat   = cs_now;
        end
    end

    // read data path and bus drive
    always_comb begin
        next_bus_oe  = cs_lat && (rd_mem || !port_read_strobe_n);
        next_bus_out = mem_byte;
        if (rd_port) begin
            case (sel)
                SEL_PORT_FIRST:  next_bus_out = first_rv;
                SEL_PORT_SECOND: next_bus_out = second_rv;
                default:         next_bus_out = DIR_READ_VALUE;
            endcase
        end
    end

    // wait low for the clock after select seen during address strobe
    always_comb begin
        next_wait_oe = addr_strobe && cs_now;
    end

    // register the bus-side state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_lat                <= ADDR_RESET;
            high_lat                <= '0;
            io_lat                  <= 1'b0;
            cs_lat                  <= 1'b0;
            wr_n_q                  <= 1'b1;
            muxed_addr_data_bus_out <= ADDR_RESET;
            muxed_addr_data_bus_oe  <= 1'b0;
            bus_wait_out            <= 1'b0;
            bus_wait_oe             <= 1'b0;
        end else begin
            addr_lat                <= next_addr_lat;
            high_lat                <= next_high_lat;
            io_lat                  <= next_io_lat;
            cs_lat                  <= next_cs_lat;
            wr_n_q                  <= port_write_strobe_n;
            muxed_addr_data_bus_out <= next_bus_out;
            muxed_addr_data_bus_oe  <= next_bus_oe;
            bus_wait_out            <= 1'b0;   // only ever drives low
            bus_wait_oe             <= next_wait_oe;
        end
    end

    // first port and its direction register
    epb_io_port #(
        .WIDTH (PORT_W)
    ) u_first (
        .clk        (clk),
        .rst        (rst),
        .wr_data    (muxed_addr_data_bus_in),
        .stage_data (wr_sel && sel == SEL_PORT_FIRST),
        .stage_dir  (wr_sel && sel == SEL_DIR_FIRST),
        .commit     (commit),
        .pins_in    (first_port_pins_in),
        .pins_out   (first_port_pins_out),
        .pins_oe    (first_port_pins_oe),
        .read_value (first_rv)
    );

    // second port and its direction register
    epb_io_port #(
        .WIDTH (PORT_W)
    ) u_second (
        .clk        (clk),
        .rst        (rst),
        .wr_data    (muxed_addr_data_bus_in),
        .stage_data (wr_sel && sel == SEL_PORT_SECOND),
        .stage_dir  (wr_sel && sel == SEL_DIR_SECOND),
        .commit     (commit),
        .pins_in    (second_port_pins_in),
        .pins_out   (second_port_pins_out),
        .pins_oe    (second_port_pins_oe),
        .read_value (second_rv)
    );

    // checks on the bus slave and port behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // address latch and chip select qualification
    a_latch_hold: assert property (!addr_strobe |=> $stable(addr_lat) && $stable(cs_lat))
        else $error("address latch changed outside strobe");
    a_unselected_float: assert property (!cs_lat |=> !muxed_addr_data_bus_oe)
        else $error("bus driven while not selected");
    a_wait_unselected: assert property (addr_strobe && !cs_now |=> !bus_wait_oe)
        else $error("wait pulled low while not selected");

    // bus drive and read data
    a_bus_float_idle: assert property (mem_read_strobe_n && port_read_strobe_n
        |=> !muxed_addr_data_bus_oe)
        else $error("bus driven with both read strobes high");
    a_bus_drive_read: assert property (cs_lat && !addr_strobe && !mem_read_strobe_n
        |=> muxed_addr_data_bus_oe ##1 1'b1)
        else $error("bus not driven during read");
    a_mem_data: assert property (cs_lat && !io_lat && rd_mem && port_read_strobe_n
        |=> muxed_addr_data_bus_out == $past(mem_byte))
        else $error("wrong memory byte on bus");
    a_port_read_first: assert property (cs_lat && rd_port && sel == SEL_PORT_FIRST
        |=> muxed_addr_data_bus_out == $past(first_rv))
        else $error("wrong first port value on bus");
    a_port_read_second: assert property (cs_lat && rd_port && sel == SEL_PORT_SECOND
        |=> muxed_addr_data_bus_out == $past(second_rv))
        else $error("wrong second port value on bus");
    a_dir_no_read: assert property (cs_lat && rd_port && sel[1]
        |=> muxed_addr_data_bus_out == DIR_READ_VALUE)
        else $error("direction register leaked on read");

    // wait output pulse
    a_wait_low: assert property (addr_strobe && cs_now
        |=> bus_wait_oe && !bus_wait_out)
        else $error("wait not pulled low");
    a_wait_release: assert property (!addr_strobe |=> !bus_wait_oe)
        else $error("wait not released");

    // port writes, pin drivers and reset
    a_pins_glitch_free: assert property (!port_write_strobe_n
        |=> $stable(first_port_pins_out) && $stable(first_port_pins_oe)
            && $stable(second_port_pins_out) && $stable(second_port_pins_oe))
        else $error("pins changed while write strobe low");
    a_port_write_first: assert property (cs_lat && !port_write_strobe_n
        && sel == SEL_PORT_FIRST ##1 port_write_strobe_n
        |=> first_port_pins_out == $past(muxed_addr_data_bus_in, 2))
        else $error("first port pins not loaded on strobe release");
    a_dir_write_second: assert property (cs_lat && !port_write_strobe_n
        && sel == SEL_DIR_SECOND ##1 port_write_strobe_n
        |=> second_port_pins_oe == $past(muxed_addr_data_bus_in, 2))
        else $error("second direction not applied on strobe release");
    a_reset_inputs: assert property (disable iff (1'b0)
        rst |-> first_port_pins_oe == DIR_RESET && second_port_pins_oe == DIR_RESET)
        else $error("pins not inputs during reset");
    a_reset_float: assert property (disable iff (1'b0)
        rst |-> !muxed_addr_data_bus_oe && !bus_wait_oe)
        else $error("bus or wait driven during reset");

    // main scenarios reached
    c_mem_read: cover property (cs_lat && !io_lat && rd_mem ##1 muxed_addr_data_bus_oe);
    c_port_write: cover property (wr_sel ##1 commit);
    c_dir_write: cover property (wr_sel && sel == SEL_DIR_SECOND ##[1:20] commit);
    c_port_read: cover property (cs_lat && !port_read_strobe_n && sel == SEL_PORT_SECOND);
    c_wait_pulse: cover property (addr_strobe && cs_now ##1 bus_wait_oe);
endmodule : epb_eprom_io_bus_port

// >>> sim/epb_cpu_model.sv
// processor-side bus model: address phases, read and write strobes
`timescale 1ns/100ps
module epb_cpu_model (
    // clock and device answers
    input  wire logic       clk,
    input  wire logic       wait_oe,
    input  wire logic       dev_oe,
    input  wire logic [7:0] dev_data,
    // bus cycle drive
    output logic      [7:0] drv,
    output logic            drv_en,
    output logic            ale,
    output logic            io_sel,
    output logic      [2:0] high_addr,
    output logic            cs_low_n,
    output logic            cs_high,
    output logic            mem_rd_n,
    output logic            port_rd_n,
    output logic            port_wr_n
);
    // idle bus at time zero
    initial begin
        {drv, drv_en, ale, io_sel, high_addr, cs_high} = '0;
        {cs_low_n, mem_rd_n, port_rd_n, port_wr_n} = 4'hf;
    end
    // address phase, reports wait while strobe high and after it falls
    task automatic addr(input logic io, input logic sel, input logic [10:0] a,
                        output logic w_on, output logic w_off);
        @(negedge clk);
        {ale, io_sel, high_addr, drv, drv_en} = {1'b1, io, a, 1'b1};
        {cs_low_n, cs_high} = {!sel, sel};
        @(negedge clk);
        w_on = wait_oe;
        {ale, drv_en} = 2'h0;
        @(negedge clk);
        w_off = wait_oe;
    endtask : addr
    // one read pulse on the port or memory strobe
    task automatic rd(input logic port, output logic oe, output logic [7:0] d,
                      output logic oe_after);
        @(negedge clk);
        if (port) port_rd_n = 1'b0;
        else mem_rd_n = 1'b0;
        @(negedge clk);
        oe = dev_oe;
        d = dev_data;
        {port_rd_n, mem_rd_n} = 2'h3;
        @(negedge clk);
        oe_after = dev_oe;
    endtask : rd
    // one write pulse, strobe high two cycles afterwards
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        {drv, drv_en, port_wr_n} = {d, 2'h2};
        @(negedge clk);
        {drv_en, port_wr_n} = 2'h1;
        repeat (2) @(negedge clk);
    endtask : wr
endmodule : epb_cpu_model

// >>> sim/tb_top.sv
// self-checking bench for the program-memory and i/o bus port
`timescale 1ns/100ps
module tb_top;
    import epb_pkg::*;
    // memory pattern: byte n = low address xor high bits in the top
    function automatic logic [MEM_DEPTH*8-1:0] mem_pat();
        for (int n = 0; n < MEM_DEPTH; n++) mem_pat[8*n+:8] = n[7:0] ^ {n[10:8], 5'h0};
    endfunction : mem_pat
    localparam logic [MEM_DEPTH*8-1:0] MEM_PAT = mem_pat();
    logic       clk, rst, drv_en, ale, io_sel, csl_n, csh, mrd_n, prd_n, pwr_n;
    logic       bus_oe, w_out, w_oe, w_on, w_off, oe, oe_after;
    logic [2:0] high_addr;
    logic [7:0] drv, bus_in, bus_out, rd_data, p_out [2], p_oe [2], p_ext [2];
    int         n_mismatch, tests_run, cycles;
    // wire levels from all drivers; released bus shows inverse
    assign bus_in = bus_oe ? bus_out : (drv_en ? drv : ~drv);
    epb_cpu_model cpu (.clk(clk), .wait_oe(w_oe), .dev_oe(bus_oe), .dev_data(bus_out),
        .drv(drv), .drv_en(drv_en), .ale(ale), .io_sel(io_sel), .high_addr(high_addr),
        .cs_low_n(csl_n), .cs_high(csh), .mem_rd_n(mrd_n), .port_rd_n(prd_n),
        .port_wr_n(pwr_n));
    epb_eprom_io_bus_port #(.MEM_INIT(MEM_PAT)) dut (.clk(clk), .rst(rst),
        .muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(bus_out),
        .muxed_addr_data_bus_oe(bus_oe), .addr_strobe(ale), .mem_io_select(io_sel),
        .high_prom_address(high_addr), .chip_select_low_active_n(csl_n),
        .chip_select_high_active(csh), .mem_read_strobe_n(mrd_n),
        .port_read_strobe_n(prd_n), .port_write_strobe_n(pwr_n), .bus_wait_out(w_out),
        .bus_wait_oe(w_oe), .first_port_pins_in((p_oe[0] & p_out[0]) | (~p_oe[0] & p_ext[0])),
        .first_port_pins_out(p_out[0]), .first_port_pins_oe(p_oe[0]),
        .second_port_pins_in((p_oe[1] & p_out[1]) | (~p_oe[1] & p_ext[1])),
        .second_port_pins_out(p_out[1]), .second_port_pins_oe(p_oe[1]));
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : chk_bit
    // per port: latch before driver on, direction, reads by both strobes
    task automatic t_ports();
        logic [7:0] dat;
        logic [7:0] dir;
        for (int k = 0; k < 2; k++) begin
            dat = k ? 8'h5a : 8'ha5;
            dir = k ? 8'h0f : 8'hf0;
            cpu.addr(1'b0, 1'b1, {3'h5, 6'h0, 1'b0, k[0]}, w_on, w_off);
            cpu.wr(dat);
            chk(p_oe[k], 8'h00, "driver stays off");
            chk(p_out[k], dat, "latch loaded with memory select low");
            cpu.addr(1'b1, 1'b1, {3'h2, 6'h0, 1'b1, k[0]}, w_on, w_off);
            fork
                cpu.wr(dir);
                begin
                    repeat (2) @(negedge clk);
                    chk(p_oe[k], 8'h00, "no change while strobe low");
                end
            join
            chk(p_oe[k], dir, "direction per bit");
            chk(p_oe[1-k], k ? 8'hf0 : 8'h00, "other port untouched");
            for (int s = 0; s < 2; s++) begin
                cpu.addr(1'b1, 1'b1, {3'h7, 6'h0, 1'b0, k[0]}, w_on, w_off);
                cpu.rd(s[0], oe, rd_data, oe_after);
                chk(rd_data, (dat & dir) | (p_ext[k] & ~dir), "port read");
                chk_bit(oe, 1'b1, "drive during read");
                chk_bit(oe_after, 1'b0, "float after read");
            end
        end
    endtask : t_ports
    // memory bytes at full address, wait pulse, direction read-back
    task automatic t_mem();
        cpu.addr(1'b0, 1'b1, 11'h5a3, w_on, w_off);
        chk_bit(w_on, 1'b1, "wait during strobe");
        chk_bit(w_off, 1'b0, "wait released");
        chk_bit(w_out, 1'b0, "wait level low");
        cpu.rd(1'b0, oe, rd_data, oe_after);
        chk(rd_data, 8'h03, "memory byte");
        cpu.addr(1'b0, 1'b1, 11'h2c4, w_on, w_off);
        cpu.rd(1'b0, oe, rd_data, oe_after);
        chk(rd_data, 8'h84, "memory byte");
        cpu.addr(1'b1, 1'b1, 11'h002, w_on, w_off);
        cpu.rd(1'b1, oe, rd_data, oe_after);
        chk(rd_data, DIR_READ_VALUE, "direction not readable");
    endtask : t_mem
    // deselected device: no wait, no drive, no write
    task automatic t_unsel();
        cpu.addr(1'b1, 1'b0, 11'h000, w_on, w_off);
        chk_bit(w_on, 1'b0, "no wait unselected");
        cpu.rd(1'b0, oe, rd_data, oe_after);
        chk_bit(oe, 1'b0, "no drive unselected");
        cpu.wr(8'h00);
        chk(p_out[0], 8'ha5, "write ignored");
    endtask : t_unsel
    // reset in mid-run turns every pin to input
    task automatic t_reset();
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk(p_oe[0], 8'h00, "first port inputs");
        chk(p_oe[1], 8'h00, "second port inputs");
        chk_bit(bus_oe, 1'b0, "bus released");
    endtask : t_reset
    task automatic complete_run();
        $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        // raise reset after time zero so its asynchronous edge is seen
        rst = 1'b0;
        #1;
        rst = 1'b1;
        p_ext[0] = 8'h3c;
        p_ext[1] = 8'hc3;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(p_oe[0], 8'h00, "reset inputs");
        t_ports();
        t_mem();
        t_unsel();
        t_reset();
        complete_run();
    end
endmodule : tb_top
